//--- pkg/t16w_map.svh
// register offsets, field positions, reset values and fixed tops of the timer waveform control
`ifndef T16W_MAP_SVH
`define T16W_MAP_SVH
`define T16W_OFF_CTRL_A 4'h0
`define T16W_OFF_STATE 4'h4
`define T16W_OFF_IRQ_STAT 4'h8
`define T16W_OFF_IRQ_MASK 4'hc
`define T16W_CHA_MODE_HI 7
`define T16W_CHA_MODE_LO 6
`define T16W_CHB_MODE_HI 5
`define T16W_CHB_MODE_LO 4
`define T16W_FORCE_A_BIT 3
`define T16W_FORCE_B_BIT 2
`define T16W_RST_CTRL_A 8'h00
`define T16W_RST_IRQ 3'h0
`define T16W_TOP_MAX 16'hffff
`define T16W_TOP_8BIT 16'h00ff
`define T16W_TOP_9BIT 16'h01ff
`define T16W_TOP_10BIT 16'h03ff
`define T16W_BOTTOM 16'h0000
`define T16W_IRQ_OVF 0
`define T16W_IRQ_MATCH_A 1
`define T16W_IRQ_MATCH_B 2
`endif

//--- pkg/t16w_pkg.sv
// types shared by the timer waveform control block
package t16w_pkg;
    // waveform family, one-hot
    typedef enum logic [5:0] {
        T16W_NORMAL = 6'h01,
        T16W_CTC = 6'h02,
        T16W_FAST = 6'h04,
        T16W_PHASE = 6'h08,
        T16W_PFC = 6'h10,
        T16W_RSVD = 6'h20
    } t16w_kind_t;
    // where top comes from
    typedef enum logic [2:0] {
        T16W_TOP_FIXED = 3'h1,
        T16W_TOP_CMPA = 3'h2,
        T16W_TOP_CAPT = 3'h4
    } t16w_top_src_t;
    // counter point at which an event happens
    typedef enum logic [3:0] {
        T16W_AT_NOW = 4'h1,
        T16W_AT_TOP = 4'h2,
        T16W_AT_BOTTOM = 4'h4,
        T16W_AT_MAX = 4'h8
    } t16w_point_t;
    // decoded waveform mode
    typedef struct packed {
        t16w_kind_t kind;
        t16w_top_src_t top_src;
        logic [15:0] fixed_top;
        t16w_point_t update_at;
        t16w_point_t ovf_at;
    } t16w_decode_t;
    // pin drive pair
    typedef struct packed {
        logic out;
        logic oe;
    } t16w_pin_t;
    // counter state from the timer core
    typedef struct packed {
        logic tick;
        logic count_up;
        logic [15:0] count;
        logic [15:0] compare_value_a;
        logic [15:0] compare_value_b;
        logic [15:0] capture_value;
    } t16w_timer_t;
endpackage

//--- design/t16w_ctrl.sv
// waveform mode decode and compare output control for a 16-bit timer
// Contract
// - nonzero output field takes over the pin, field 01 only where it toggles
// - pin driver enabled only with direction output
// - non-PWM: disconnect, toggle, clear, set on match
// - fast PWM: clear/set on match, opposite at top
// - PWM field 01: A toggles if top bit
// - fast PWM ignores match when compare equals top and field high bit is set
// - dual slope: up-match and down-match act oppositely
// - force bits work only in non-PWM modes
// - force is a strobe acting as a match
// - force sets no flag, no counter clear
// - force bits always read as zero
// - mode is companion bits joined to low bits
// - modes 0, 4, 12 top, immediate, MAX
// - fixed-top PWM modes, update and overflow points
// - modes 8, 9 update and flag at bottom
// - modes 10, 11, 14, 15 variable top; 13 reserved
`timescale 1ns/1ps
`default_nettype none
`include "t16w_map.svh"
module t16w_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] wave_mode_high,
    input wire logic dir_a,
    input wire logic dir_b,
    input wire t16w_pkg::t16w_timer_t timer_i,
    output t16w_pkg::t16w_pin_t wave_out_a,
    output t16w_pkg::t16w_pin_t wave_out_b,
    output logic [15:0] top_value,
    output logic dual_slope,
    output logic buf_update,
    output logic overflow_set,
    output logic counter_clear,
    output logic irq
);
    import t16w_pkg::*;

    logic [7:0] ctrl_q; // timer16_control_a, force bits never stored
    logic [2:0] irq_stat_q; // sticky events
    logic [2:0] irq_mask_q; // interrupt enables
    logic ack_q; // bus answer
    logic [31:0] rdat_q; // bus read data
    logic [1:0] force_q; // force strobes, bit 1 is channel a
    logic [1:0] wave_q; // waveform state per channel
    logic [1:0] oe_q; // pin driver enables
    logic [1:0] take_q; // pin override per channel
    logic [15:0] top_q; // current top
    logic dual_q; // dual slope active
    logic upd_q; // buffer update pulse
    logic ovf_q; // overflow event pulse
    logic clr_q; // counter clear pulse
    logic irq_q; // level interrupt

    logic [3:0] wave_mode; // full four-bit mode
    t16w_decode_t dec; // decoded mode
    logic [15:0] top_now; // top selected by mode
    logic non_pwm; // normal or clear_on_match_mode
    logic at_top; // counter sits at top this tick
    logic at_bottom; // counter sits at bottom this tick
    logic at_max; // counter sits at all ones
    logic [1:0] match; // raw compare matches per channel
    logic [1:0] match_eff; // matches after the fast-PWM exception
    logic req; // new bus request
    logic wr_ctrl; // write to the control register
    logic [7:0] wmask; // byte lane 0 enable as mask
    t16w_decode_t dec_wr; // mode that the current control write selects
    logic non_pwm_wr; // written mode is normal or clear_on_match_mode

    // mode decode table
    function automatic t16w_decode_t decode(input logic [3:0] m);
        t16w_decode_t d;
        d = '{kind: T16W_NORMAL, top_src: T16W_TOP_FIXED, fixed_top: `T16W_TOP_MAX,
              update_at: T16W_AT_NOW, ovf_at: T16W_AT_MAX};
        unique case (m)
            4'h0: begin
                d.kind = T16W_NORMAL;
            end
            4'h1, 4'h2, 4'h3: begin
                d.kind = T16W_PHASE;
                d.update_at = T16W_AT_TOP;
                d.ovf_at = T16W_AT_BOTTOM;
            end
            4'h4, 4'hc: begin
                d.kind = T16W_CTC;
                d.top_src = (m[3]) ? T16W_TOP_CAPT : T16W_TOP_CMPA;
            end
            4'h5, 4'h6, 4'h7: begin
                d.kind = T16W_FAST;
                d.update_at = T16W_AT_TOP;
                d.ovf_at = T16W_AT_TOP;
            end
            4'h8, 4'h9: begin
                d.kind = T16W_PFC;
                d.top_src = (m[0]) ? T16W_TOP_CMPA : T16W_TOP_CAPT;
                d.update_at = T16W_AT_BOTTOM;
                d.ovf_at = T16W_AT_BOTTOM;
            end
            4'ha, 4'hb: begin
                d.kind = T16W_PHASE;
                d.top_src = (m[0]) ? T16W_TOP_CMPA : T16W_TOP_CAPT;
                d.update_at = T16W_AT_TOP;
                d.ovf_at = T16W_AT_BOTTOM;
            end
            4'hd: begin
                d.kind = T16W_RSVD;
            end
            4'he, 4'hf: begin
                d.kind = T16W_FAST;
                d.top_src = (m[0]) ? T16W_TOP_CMPA : T16W_TOP_CAPT;
                d.update_at = T16W_AT_TOP;
                d.ovf_at = T16W_AT_TOP;
            end
        endcase
        // fixed tops of the 8/9/10-bit modes follow the low bits
        if (m[3] == 1'b0 && m[1:0] != 2'h0) begin
            d.fixed_top = (m[1:0] == 2'h1) ? `T16W_TOP_8BIT :
                          (m[1:0] == 2'h2) ? `T16W_TOP_9BIT : `T16W_TOP_10BIT;
        end
        return d;
    endfunction

    // mode assembly and counter points
    always_comb begin
        wave_mode = {wave_mode_high, ctrl_q[1:0]};
        dec = decode(wave_mode);
        unique case (dec.top_src)
            T16W_TOP_CMPA: top_now = timer_i.compare_value_a;
            T16W_TOP_CAPT: top_now = timer_i.capture_value;
            default: top_now = dec.fixed_top;
        endcase
        non_pwm = (dec.kind == T16W_NORMAL) || (dec.kind == T16W_CTC);
        at_top = timer_i.tick && (timer_i.count == top_now);
        at_bottom = timer_i.tick && (timer_i.count == `T16W_BOTTOM);
        at_max = timer_i.tick && (timer_i.count == `T16W_TOP_MAX);
        match[1] = timer_i.tick && (timer_i.count == timer_i.compare_value_a);
        match[0] = timer_i.tick && (timer_i.count == timer_i.compare_value_b);
    end

    // bus decode; only lane 0 carries control bits
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !ack_q;
        wmask = {8{wb_sel_i[0]}};
        wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `T16W_OFF_CTRL_A);
        // strobes are judged against the mode being written, not the one it replaces
        dec_wr = decode({wave_mode_high, wb_dat_i[1:0]});
        non_pwm_wr = (dec_wr.kind == T16W_NORMAL) || (dec_wr.kind == T16W_CTC);
    end

    // classic wishbone handshake, one wait state, unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `T16W_OFF_CTRL_A: rdat_q <= {24'h000000, ctrl_q};
                    `T16W_OFF_STATE: rdat_q <= {14'h0000, dual_q, wave_mode, take_q,
                                                wave_q, top_q[8:0]};
                    `T16W_OFF_IRQ_STAT: rdat_q <= {29'h0, irq_stat_q};
                    `T16W_OFF_IRQ_MASK: rdat_q <= {29'h0, irq_mask_q};
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register; force bits are not stored so they read zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= `T16W_RST_CTRL_A;
        end else if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[7:0] & 8'hf3;
        end
    end

    // force strobes: one-cycle pulse, dropped outright in PWM modes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            force_q <= 2'h0;
        end else if (wr_ctrl && non_pwm_wr) begin
            // strobe acts next cycle, so the fields just written decide its effect
            force_q <= wb_dat_i[`T16W_FORCE_A_BIT:`T16W_FORCE_B_BIT];
        end else begin
            force_q <= 2'h0;
        end
    end

    // per-channel waveform units
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            localparam int HI = (ch == 1) ? `T16W_CHA_MODE_HI : `T16W_CHB_MODE_HI;
            logic [1:0] com; // channel output field
            logic [15:0] cmp; // channel compare value
            logic tog_ok; // field 01 is live
            logic connected; // channel owns the pin
            always_comb begin
                com = ctrl_q[HI -: 2];
                cmp = (ch == 1) ? timer_i.compare_value_a : timer_i.compare_value_b;
                // in PWM, 01 toggles only channel a with the top mode bit set
                tog_ok = non_pwm || (wave_mode[3] && ch == 1);
                connected = (com != 2'h0) && (com != 2'h1 || tog_ok);
                // a compare equal to top is ignored in fast pwm when the high bit is set
                match_eff[ch] = match[ch] && !(dec.kind == T16W_FAST && com[1]
                                               && cmp == top_now);
            end

            // waveform state
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    wave_q[ch] <= 1'b0;
                end else if (dec.kind == T16W_RSVD) begin
                    wave_q[ch] <= wave_q[ch]; // mode 13 holds the output
                end else if (com == 2'h1) begin
                    if (tog_ok && (match_eff[ch] || force_q[ch])) begin
                        wave_q[ch] <= !wave_q[ch];
                    end
                end else if (com[1]) begin
                    if (non_pwm) begin
                        if (match_eff[ch] || force_q[ch]) begin
                            wave_q[ch] <= com[0];
                        end
                    end else if (dec.kind == T16W_FAST) begin
                        if (at_top) begin
                            wave_q[ch] <= !com[0];
                        end else if (match_eff[ch]) begin
                            wave_q[ch] <= com[0];
                        end
                    end else if (match_eff[ch]) begin
                        // dual slope: up-count match acts like fast, down-count inverts
                        wave_q[ch] <= timer_i.count_up ? com[0] : !com[0];
                    end
                end
            end

            // pin takeover and driver enable
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    take_q[ch] <= 1'b0;
                    oe_q[ch] <= 1'b0;
                end else begin
                    take_q[ch] <= connected;
                    oe_q[ch] <= connected && ((ch == 1) ? dir_a : dir_b);
                end
            end
        end
    endgenerate

    // timing outputs toward the counter and buffers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            top_q <= `T16W_TOP_MAX;
            dual_q <= 1'b0;
            upd_q <= 1'b0;
            ovf_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            top_q <= top_now;
            dual_q <= (dec.kind == T16W_PHASE) || (dec.kind == T16W_PFC);
            unique case (dec.update_at)
                T16W_AT_TOP: upd_q <= at_top;
                T16W_AT_BOTTOM: upd_q <= at_bottom;
                default: upd_q <= 1'b1;
            endcase
            unique case (dec.ovf_at)
                T16W_AT_TOP: ovf_q <= at_top;
                T16W_AT_BOTTOM: ovf_q <= at_bottom && !timer_i.count_up;
                default: ovf_q <= at_max;
            endcase
            // only a real match clears; a forced compare never does
            clr_q <= (dec.kind == T16W_CTC) && at_top;
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_stat_q <= `T16W_RST_IRQ;
            irq_mask_q <= `T16W_RST_IRQ;
        end else begin
            // forced compares never reach these flags
            irq_stat_q <= (irq_stat_q & ~((req && wb_we_i && wb_adr_i == `T16W_OFF_IRQ_STAT)
                            ? wb_dat_i[2:0] & wmask[2:0] : 3'h0))
                          | {match_eff[0], match_eff[1], ovf_q};
            if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `T16W_OFF_IRQ_MASK) begin
                irq_mask_q <= wb_dat_i[2:0];
            end
        end
    end

    // interrupt level
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // outputs straight from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign wave_out_a = '{out: wave_q[1], oe: oe_q[1]};
    assign wave_out_b = '{out: wave_q[0], oe: oe_q[0]};
    assign top_value = top_q;
    assign dual_slope = dual_q;
    assign buf_update = upd_q;
    assign overflow_set = ovf_q;
    assign counter_clear = clr_q;
    assign irq = irq_q;

    // checks
    a_oe_needs_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
        oe_q[1] |-> $past(dir_a)) else $error("pin a driven without direction");
    a_oe_needs_field: assert property (@(posedge core_clk) disable iff (!rst_n)
        oe_q[0] |-> $past(ctrl_q[5:4]) != 2'h0) else $error("pin b driven, field zero");
    a_force_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        ack_q && $past(!wb_we_i && wb_adr_i == `T16W_OFF_CTRL_A) |-> wb_dat_o[3:2] == 2'h0)
        else $error("force bits read nonzero");
    a_force_pwm_dead: assert property (@(posedge core_clk) disable iff (!rst_n)
        (force_q != 2'h0) |-> non_pwm) else $error("force in pwm mode");
    a_nonpwm_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (non_pwm && ctrl_q[7:6] == 2'h2 && match[1]) |=> !wave_q[1])
        else $error("clear on match failed");
    a_fast_top_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dec.kind == T16W_FAST && ctrl_q[5:4] == 2'h2 && at_top) |=> wave_q[0])
        else $error("fast pwm top set failed");
    a_dual_down_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dec.kind == T16W_PFC && ctrl_q[7:6] == 2'h2 && match[1] && !timer_i.count_up)
        |=> wave_q[1]) else $error("down-count match did not set");
    a_force_no_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (force_q[1] && !at_top) |=> !clr_q) else $error("force cleared counter");
    a_fast_ovf_top: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dec.kind == T16W_FAST && at_top) |=> ovf_q && upd_q)
        else $error("fast pwm top events missing");
    a_pfc_bottom: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dec.kind == T16W_PFC && !at_bottom) |=> !upd_q && !ovf_q)
        else $error("pfc event off bottom");
    a_normal_top: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wave_mode == 4'h0) |=> top_q == `T16W_TOP_MAX) else $error("normal top wrong");
    a_reserved_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wave_mode == 4'hd) |=> $stable(wave_q)) else $error("mode 13 moved output");
endmodule
`default_nettype wire

//--- testbench/t16w_tb.sv
// self-checking bench for the timer waveform mode and compare output control
`timescale 1ns/1ps
`default_nettype none
`include "t16w_map.svh"
module testbench;
    import t16w_pkg::*;
    logic core_clk = 1'b0; // 40 MHz
    logic rst_n = 1'b0; // synchronous, active low
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] wave_mode_high = 2'h0; // companion mode bits
    logic dir_a = 1'b0;
    logic dir_b = 1'b0;
    t16w_timer_t tmr = '0; // counter state played by the bench
    t16w_pin_t wave_out_a;
    t16w_pin_t wave_out_b;
    logic [15:0] top_value;
    logic dual_slope;
    logic buf_update;
    logic overflow_set;
    logic counter_clear;
    logic irq;
    logic [31:0] rd; // last read data
    int err_total = 0;
    int n_tests = 0;

    // free-running clock
    always #12.5 core_clk = ~core_clk;

    t16w_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wave_mode_high(wave_mode_high), .dir_a(dir_a), .dir_b(dir_b), .timer_i(tmr),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .top_value(top_value),
        .dual_slope(dual_slope), .buf_update(buf_update), .overflow_set(overflow_set),
        .counter_clear(counter_clear), .irq(irq));

    // word compare, four-state exact
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // single flag compare
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // classic single cycle; the wait is bounded so a dead slave cannot hang us
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
            $display("ERROR t=%0t ack=%0h exp=%0h", $time, wb_ack_o, 1'b1);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask

    // mode, both output fields and force strobes {a,b}, then let pins settle
    task automatic set_ctrl(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb,
                            input logic [1:0] frc);
        wave_mode_high <= m[3:2];
        wb_xfer(1'b1, `T16W_OFF_CTRL_A, {24'h0, ca, cb, frc, m[1:0]});
        repeat (2) @(posedge core_clk);
    endtask

    // one timer tick; returns when its pulses are visible
    task automatic do_tick(input logic [15:0] cnt, input logic up);
        @(posedge core_clk);
        tmr.tick <= 1'b1;
        tmr.count <= cnt;
        tmr.count_up <= up;
        @(posedge core_clk);
        tmr.tick <= 1'b0;
        // look while the one-cycle pulses still stand
        @(negedge core_clk);
    endtask

    // expected top for each mode
    function automatic logic [15:0] exp_top(input int m);
        case (m)
            1, 5: return `T16W_TOP_8BIT;
            2, 6: return `T16W_TOP_9BIT;
            3, 7: return `T16W_TOP_10BIT;
            4, 9, 11, 15: return tmr.compare_value_a;
            8, 10, 12, 14: return tmr.capture_value;
            default: return `T16W_TOP_MAX;
        endcase
    endfunction

    function automatic logic exp_dual(input int m);
        return (m >= 1 && m <= 3) || (m >= 8 && m <= 11);
    endfunction

    // counter value at which the overflow flag is due
    function automatic logic [15:0] ovf_cnt(input int m);
        if (m == 0 || m == 4 || m == 12) return `T16W_TOP_MAX;
        if (exp_dual(m)) return `T16W_BOTTOM;
        return exp_top(m);
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected run of a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end

    initial begin
        logic [7:0] v;
        logic prev;
        void'($urandom(32'h29dd8c4d));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk_word(top_value, `T16W_TOP_MAX);
        wb_xfer(1'b0, `T16W_OFF_CTRL_A, 32'h0);
        chk_word(rd, 32'h0);
        // every mode: top, slope, buffer point; overflow point for all but mode 13
        for (int m = 0; m < 16; m++) begin
            tmr.compare_value_a <= 16'h0100 | 16'($urandom_range(32'h7fff));
            tmr.capture_value <= 16'h0100 | 16'($urandom_range(32'h7fff));
            set_ctrl(4'(m), 2'h0, 2'h0, 2'h0);
            chk_word(top_value, exp_top(m));
            chk_bit(dual_slope, exp_dual(m));
            chk_bit(buf_update, m == 0 || m == 4 || m == 12 || m == 13);
            wb_xfer(1'b0, `T16W_OFF_STATE, 32'h0);
            chk_word(rd[17:13], {exp_dual(m), 4'(m)});
            if (m != 13) begin
                do_tick(ovf_cnt(m), !exp_dual(m));
                chk_bit(overflow_set, 1'b1);
            end
        end
        // random control values read back without the strobes
        repeat (4) begin
            v = 8'($urandom);
            set_ctrl({2'h0, v[1:0]}, v[7:6], v[5:4], v[3:2]);
            wb_xfer(1'b0, `T16W_OFF_CTRL_A, 32'h0);
            chk_word(rd, {24'h0, v & 8'hf3});
        end
        // forced compares in clear-on-match mode
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        wb_xfer(1'b1, `T16W_OFF_IRQ_STAT, 32'h7);
        set_ctrl(4'h4, 2'h2, 2'h2, 2'h3);
        chk_word({wave_out_a, wave_out_b}, 32'h5);
        set_ctrl(4'h4, 2'h1, 2'h3, 2'h3);
        chk_word({wave_out_a, wave_out_b}, 32'hf);
        wb_xfer(1'b0, `T16W_OFF_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h0);
        dir_a <= 1'b0;
        set_ctrl(4'h4, 2'h1, 2'h3, 2'h2);
        chk_word(wave_out_a, 32'h0);
        dir_a <= 1'b1;
        set_ctrl(4'h0, 2'h0, 2'h3, 2'h0);
        chk_bit(wave_out_a.oe, 1'b0);
        // matches from the counter, set then clear
        tmr.compare_value_a <= 16'h1234;
        for (int f = 3; f >= 2; f--) begin
            set_ctrl(4'h0, 2'(f), 2'h3, 2'h0);
            do_tick(16'h1234, 1'b1);
            chk_bit(wave_out_a.out, f == 3);
        end
        // fast pwm: action on match and opposite action at top
        tmr.compare_value_a <= 16'h0040;
        for (int f = 2; f <= 3; f++) begin
            set_ctrl(4'h5, 2'(f), 2'(f), 2'h0);
            do_tick(16'h0040, 1'b1);
            chk_bit(wave_out_a.out, f == 3);
            do_tick(16'h00ff, 1'b1);
            chk_bit(wave_out_a.out, f == 2);
        end
        tmr.compare_value_a <= 16'h00ff;
        set_ctrl(4'h5, 2'h2, 2'h0, 2'h0);
        do_tick(16'h00ff, 1'b1);
        chk_bit(wave_out_a.out, 1'b1);
        set_ctrl(4'h5, 2'h2, 2'h0, 2'h2);
        chk_bit(wave_out_a.out, 1'b1);
        set_ctrl(4'h5, 2'h1, 2'h1, 2'h0);
        chk_word({wave_out_a.oe, wave_out_b.oe}, 32'h0);
        tmr.compare_value_a <= 16'h0040;
        tmr.capture_value <= 16'h0100;
        set_ctrl(4'he, 2'h1, 2'h1, 2'h0);
        prev = wave_out_a.out;
        do_tick(16'h0040, 1'b1);
        chk_word({wave_out_a, wave_out_b.oe}, {29'h0, !prev, 2'b10});
        // dual slope: up and down matches act oppositely
        for (int f = 2; f <= 3; f++) begin
            set_ctrl((f == 2) ? 4'h9 : 4'h1, 2'(f), 2'h0, 2'h0);
            do_tick(16'h0040, 1'b1);
            chk_bit(wave_out_a.out, f == 3);
            do_tick(16'h0040, 1'b0);
            chk_bit(wave_out_a.out, f == 2);
        end
        // overflow interrupt: raise, mask, unmask, clear
        wb_xfer(1'b1, `T16W_OFF_IRQ_STAT, 32'h7);
        wb_xfer(1'b1, `T16W_OFF_IRQ_MASK, 32'h1);
        set_ctrl(4'h0, 2'h0, 2'h0, 2'h0);
        do_tick(16'hffff, 1'b1);
        repeat (2) @(negedge core_clk);
        chk_bit(irq, 1'b1);
        wb_xfer(1'b1, `T16W_OFF_IRQ_MASK, 32'h0);
        chk_bit(irq, 1'b0);
        wb_xfer(1'b0, `T16W_OFF_IRQ_STAT, 32'h0);
        chk_bit(rd[0], 1'b1);
        wb_xfer(1'b1, `T16W_OFF_IRQ_MASK, 32'h1);
        chk_bit(irq, 1'b1);
        wb_xfer(1'b1, `T16W_OFF_IRQ_STAT, 32'h1);
        chk_bit(irq, 1'b0);
        wb_xfer(1'b0, 4'h1, 32'h0);
        chk_word(rd, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
